// ### fcl_pkg.sv
//==============================================================================
//==============================================================================
package fcl_pkg;

  // Register byte addresses
  localparam logic [7:0] A_CFG  = 8'h00;
  localparam logic [7:0] A_CYC  = 8'h04;
  localparam logic [7:0] A_FILT = 8'h08;
  localparam logic [7:0] A_CTRL = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_MASK = 8'h14;
  localparam logic [7:0] A_POS  = 8'h18;
  localparam logic [7:0] A_MODE = 8'h1C;

  // Control register bits
  localparam int CTRL_APPLY = 0;
  localparam int CTRL_CMD   = 1;

  // Status / mask bit positions
  localparam int ST_PARAM = 0;
  localparam int ST_CYCLE = 1;
  localparam int ST_ENC   = 2;

  // Axis operation modes and encoder wiring kinds
  localparam logic [1:0] OPM_POSITION   = 2'h0;
  localparam logic [1:0] OPM_POSITIONING = 2'h1;
  localparam logic [1:0] ENC_TWO_WIRE   = 2'h0;
  localparam logic [1:0] ENC_FOUR_WIRE  = 2'h1;
  localparam logic [1:0] ENC_ABZ        = 2'h2;

  // Reset values
  localparam logic [19:0] CYC_RST  = 20'h0F424;
  localparam logic [12:0] FILT_RST = 13'h0064;
  localparam logic [2:0]  MASK_RST = 3'h0;

  // Timing: clock, control update period, cycle thresholds
  localparam int CLK_PERIOD_NS  = 40;
  localparam int CTL_PERIOD_NS  = 1000;
  localparam int CTL_DIV        = CTL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CYC_MIN_1AX_US = 125;
  localparam int CYC_MIN_2AX_US = 250;
  localparam logic [19:0] CYC_MIN_1AX_NS = 20'(CYC_MIN_1AX_US * 1000);
  localparam logic [19:0] CYC_MIN_2AX_NS = 20'(CYC_MIN_2AX_US * 1000);

  // Filter: setting forcing full loop, band scaling to 1 us update gain
  localparam logic [12:0] FILT_FORCE_FULL = 13'(4500);
  localparam int FILT_K_NUM   = 67;
  localparam int FILT_K_SHIFT = 10;

  typedef enum logic [1:0] {M_SEMI, M_DUAL, M_FULL} fcl_method_e;

  typedef struct packed {
    logic [1:0] load_enc;
    logic [1:0] motor_enc;
    logic [1:0] opmode;
    logic       sw_sel;
    logic       fcl_en;
    logic [1:0] axes;
  } fcl_cfg_s;

endpackage

// ### fcl_sync3.sv
`timescale 1ns/10ps
module fcl_sync3 (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Pin in, filtered level out
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic [2:0] s;
    logic       q;
  } fcl_sync_s;

  fcl_sync_s s_r;
  fcl_sync_s s_nxt;

  //==========================================================================
  // Three stages; level changes only once stages two and three agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.s = {s_r.s[1:0], din};
    if (s_r.s[1] == s_r.s[2]) begin
      s_nxt.q = s_r.s[2];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.q;

endmodule

// ### fcl_dfb.sv
`timescale 1ns/10ps
module fcl_dfb (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Update enable and band gain
  input  wire logic               ce,
  input  wire logic        [15:0] k,
  // Feedback positions
  input  wire logic signed [31:0] motor,
  input  wire logic signed [31:0] load,
  output logic signed      [31:0] fb
);

  typedef struct packed {
    logic signed [47:0] e;
    logic signed [31:0] fb;
  } fcl_dfb_s;

  fcl_dfb_s           s_r;
  fcl_dfb_s           s_nxt;
  logic signed [31:0] diff;
  logic signed [48:0] d;
  logic signed [65:0] prod;

  //==========================================================================
  // Low-pass of (load - motor) added to motor equals load low-pass plus
  // motor high-pass; one accumulator instead of two filters saves a multiplier
  always_comb begin
    s_nxt = s_r;
    diff = load - motor;
    d = 49'(signed'({diff, 16'h0000})) - 49'(s_r.e);
    prod = 66'(d) * 66'(signed'({1'b0, k}));
    if (ce) begin
      s_nxt.e = s_r.e + 48'(prod >>> 16);
    end
    s_nxt.fb = motor + s_r.e[47:16];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fb = s_r.fb;

endmodule

// ### fcl_top.sv
`timescale 1ns/10ps
module fcl_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Loop select pin and feedback
  input  wire logic        cld_pin,
  input  wire logic [31:0] motor_pos,
  input  wire logic [31:0] load_pos,
  // Loop outputs
  output logic      [31:0] fb_pos,
  output logic             fcl_run,
  output logic      [1:0]  method,
  // Alarms and interrupt
  output logic             parameter_error_alarm,
  output logic             comm_cycle_setting_warning,
  output logic             load_encoder_error_alarm,
  output logic             irq
);

  typedef struct packed {
    fcl_pkg::fcl_cfg_s   cfg;
    logic [19:0]         cyc;
    logic [12:0]         filt;
    logic                cmd;
    logic [2:0]          fault;
    logic [2:0]          stat;
    logic [2:0]          mask;
    logic [31:0]         rdata;
    logic                irq;
    logic                run;
    fcl_pkg::fcl_method_e method;
    logic [31:0]         fb;
    logic [4:0]          div;
    logic                ce;
  } fcl_top_s;

  fcl_top_s    s_r;
  fcl_top_s    s_nxt;
  logic        cld;
  logic [31:0] dfb_out;
  logic [15:0] k;
  logic        apply;
  logic [2:0]  chk;
  logic [2:0]  w1c;

  //==========================================================================
  // Pin synchroniser and blending filter
  fcl_sync3 u_cld (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (cld_pin),
    .dout  (cld)
  );

  // Band setting scaled to a per-update gain
  assign k = 16'((32'(s_r.filt) * 32'(fcl_pkg::FILT_K_NUM)) >> fcl_pkg::FILT_K_SHIFT);

  fcl_dfb u_dfb (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (s_r.ce),
    .k     (k),
    .motor (motor_pos),
    .load  (load_pos),
    .fb    (dfb_out)
  );

  //==========================================================================
  // Configuration check, evaluated only when software applies the set
  always_comb begin
    apply = wr && (addr == fcl_pkg::A_CTRL) && wdata[fcl_pkg::CTRL_APPLY];
    w1c = (wr && (addr == fcl_pkg::A_STAT)) ? wdata[2:0] : 3'h0;
    chk = 3'h0;
    if (s_r.cfg.fcl_en) begin
      chk[fcl_pkg::ST_PARAM] = (s_r.cfg.axes == 2'h3)
        || !((s_r.cfg.opmode == fcl_pkg::OPM_POSITION)
        || (s_r.cfg.opmode == fcl_pkg::OPM_POSITIONING));
      chk[fcl_pkg::ST_CYCLE] = ((s_r.cfg.axes == 2'h1) && (s_r.cyc < fcl_pkg::CYC_MIN_1AX_NS))
        || ((s_r.cfg.axes == 2'h2) && (s_r.cyc < fcl_pkg::CYC_MIN_2AX_NS));
      chk[fcl_pkg::ST_ENC] = (s_r.cfg.axes == 2'h2)
        && ((s_r.cfg.load_enc == fcl_pkg::ENC_ABZ)
        || (s_r.cfg.load_enc != fcl_pkg::ENC_TWO_WIRE)
        || (s_r.cfg.motor_enc != fcl_pkg::ENC_TWO_WIRE));
    end
  end

  //==========================================================================
  // Next state: registers, status, loop selection, feedback mux, read port
  always_comb begin
    s_nxt = s_r;
    // Control update enable, one pulse per microsecond
    s_nxt.ce = 1'b0;
    if (s_r.div == 5'(fcl_pkg::CTL_DIV - 1)) begin
      s_nxt.div = 5'h00;
      s_nxt.ce = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 5'h01;
    end
    // Register writes
    if (wr) begin
      unique case (addr)
        fcl_pkg::A_CFG:  s_nxt.cfg = wdata[9:0];
        fcl_pkg::A_CYC:  s_nxt.cyc = wdata[19:0];
        fcl_pkg::A_FILT: s_nxt.filt = wdata[12:0];
        fcl_pkg::A_CTRL: s_nxt.cmd = wdata[fcl_pkg::CTRL_CMD];
        fcl_pkg::A_MASK: s_nxt.mask = wdata[2:0];
        default: ;
      endcase
    end
    // Faults follow the last apply; sticky status set wins over clear
    if (apply) begin
      s_nxt.fault = chk;
    end
    s_nxt.stat = (s_r.stat & ~w1c) | (apply ? chk : 3'h0);
    // Next mask as well as next status, so masking takes effect in the write cycle
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    // Warnings never stop the loop; alarms do
    s_nxt.run = s_r.cfg.fcl_en && !s_nxt.fault[fcl_pkg::ST_PARAM]
      && !s_nxt.fault[fcl_pkg::ST_ENC];
    // Control method
    if (!s_r.run) begin
      s_nxt.method = fcl_pkg::M_SEMI;
    end else if (s_r.cfg.sw_sel && !(s_r.cmd || cld)) begin
      s_nxt.method = fcl_pkg::M_SEMI;
    end else if (s_r.filt == fcl_pkg::FILT_FORCE_FULL) begin
      s_nxt.method = fcl_pkg::M_FULL;
    end else begin
      s_nxt.method = fcl_pkg::M_DUAL;
    end
    // Feedback source; position units follow the chosen encoder
    unique case (s_r.method)
      fcl_pkg::M_SEMI: s_nxt.fb = motor_pos;
      fcl_pkg::M_FULL: s_nxt.fb = load_pos;
      fcl_pkg::M_DUAL: s_nxt.fb = dfb_out;
      default:         s_nxt.fb = motor_pos;
    endcase
    // Read data valid only in the cycle after the strobe
    s_nxt.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        fcl_pkg::A_CFG:  s_nxt.rdata = {22'h000000, s_r.cfg};
        fcl_pkg::A_CYC:  s_nxt.rdata = {12'h000, s_r.cyc};
        fcl_pkg::A_FILT: s_nxt.rdata = {19'h00000, s_r.filt};
        fcl_pkg::A_CTRL: s_nxt.rdata = {30'h00000000, s_r.cmd, 1'b0};
        fcl_pkg::A_STAT: s_nxt.rdata = {29'h00000000, s_r.stat};
        fcl_pkg::A_MASK: s_nxt.rdata = {29'h00000000, s_r.mask};
        fcl_pkg::A_POS:  s_nxt.rdata = s_r.fb;
        fcl_pkg::A_MODE: s_nxt.rdata = {25'h0000000, s_r.fault, cld, s_r.run, s_r.method};
        default:         s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  //==========================================================================
  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.cyc <= fcl_pkg::CYC_RST;
      s_r.filt <= fcl_pkg::FILT_RST;
      s_r.mask <= fcl_pkg::MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  //==========================================================================
  // Outputs, all straight from the state register
  assign rdata = s_r.rdata;
  assign fb_pos = s_r.fb;
  assign fcl_run = s_r.run;
  assign method = s_r.method;
  assign parameter_error_alarm = s_r.stat[fcl_pkg::ST_PARAM];
  assign comm_cycle_setting_warning = s_r.stat[fcl_pkg::ST_CYCLE];
  assign load_encoder_error_alarm = s_r.stat[fcl_pkg::ST_ENC];
  assign irq = s_r.irq;

  //==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_THREE_AXIS: assert property (apply && s_r.cfg.fcl_en && s_r.cfg.axes == 2'h3
    |=> s_r.stat[fcl_pkg::ST_PARAM] && !s_r.run)
    else $error("three-axis fully closed loop not refused");
  AST_OPMODE: assert property (apply && s_r.cfg.fcl_en && s_r.cfg.opmode[1]
    |=> s_r.stat[fcl_pkg::ST_PARAM] ##1 s_r.method == fcl_pkg::M_SEMI)
    else $error("fully closed loop allowed outside position modes");
  AST_CYC_1AX: assert property (apply && s_r.cfg.fcl_en && s_r.cfg.axes == 2'h1
    && s_r.cyc < fcl_pkg::CYC_MIN_1AX_NS |=> s_r.stat[fcl_pkg::ST_CYCLE] && comm_cycle_setting_warning)
    else $error("one-axis short cycle warning missing");
  AST_CYC_2AX: assert property (apply && s_r.cfg.fcl_en && s_r.cfg.axes == 2'h2
    && s_r.cyc < fcl_pkg::CYC_MIN_2AX_NS |=> s_r.stat[fcl_pkg::ST_CYCLE])
    else $error("two-axis short cycle warning missing");
  AST_ABZ_2AX: assert property (apply && s_r.cfg.fcl_en && s_r.cfg.axes == 2'h2
    && s_r.cfg.load_enc == fcl_pkg::ENC_ABZ |=> load_encoder_error_alarm && !fcl_run)
    else $error("A/B/Z load encoder on two axes not flagged");
  AST_WIRE_2AX: assert property (apply && s_r.cfg.fcl_en && s_r.cfg.axes == 2'h2
    && s_r.cfg.motor_enc == fcl_pkg::ENC_FOUR_WIRE |=> s_r.stat[fcl_pkg::ST_ENC])
    else $error("four-wire motor encoder on two axes not flagged");
  AST_SEMI_FB: assert property (s_r.method == fcl_pkg::M_SEMI
    |=> fb_pos == $past(motor_pos))
    else $error("semi closed loop not on motor position");
  AST_FULL_FB: assert property (s_r.method == fcl_pkg::M_FULL
    |=> fb_pos == $past(load_pos))
    else $error("fully closed loop not on load position");
  AST_SWITCH: assert property (s_r.run && s_r.cfg.sw_sel && !s_r.cmd && !cld
    |=> s_r.method == fcl_pkg::M_SEMI)
    else $error("switch select off did not give semi closed loop");
  AST_FORCE_FULL: assert property (s_r.run && !s_r.cfg.sw_sel
    && s_r.filt == fcl_pkg::FILT_FORCE_FULL |=> s_r.method == fcl_pkg::M_FULL)
    else $error("setting 4500 did not force full loop");
  AST_HOLD: assert property (s_r.stat[fcl_pkg::ST_PARAM] && !(w1c[fcl_pkg::ST_PARAM])
    |=> s_r.stat[fcl_pkg::ST_PARAM])
    else $error("parameter alarm dropped without clear");

  COV_DUAL: cover property (s_r.method == fcl_pkg::M_DUAL ##1 s_r.ce);
  COV_ALARM_IRQ: cover property (s_r.stat[fcl_pkg::ST_PARAM] && irq);
  COV_SWITCH: cover property (s_r.method == fcl_pkg::M_SEMI && s_r.run ##1 s_r.method == fcl_pkg::M_DUAL);

endmodule

// ### fcl_enc_model.sv
`timescale 1ns/10ps
// ==============================================================
// Encoder pair seen by the feedback block
module fcl_enc_model #(
  parameter int LOAD_PPR = 4096
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Motion control from the bench
  input  wire logic [7:0]  speed,
  input  wire logic [31:0] gap,
  // Positions towards the block
  output logic      [31:0] motor_pos,
  output logic      [31:0] load_pos
);
  logic [31:0] motor_r;

  // Load resolution checked against the supported span, with a message if outside
  initial begin
    if (LOAD_PPR < 4096 || LOAD_PPR > 67108864) begin
      $display("encoder model resolution out of span");
    end
  end

  // Two-wire serial motor encoder, never an A/B/Z one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      motor_r <= 32'h0;
    end else begin
      motor_r <= motor_r + {24'h0, speed};
    end
  end

  // Load side leads the motor by a fixed twist, given in load units
  assign motor_pos = motor_r;
  assign load_pos  = motor_r + gap; // Twist stands in for compliance
endmodule

// ### fully_closed_loop_position_feedback_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ==============================================================
// Self-checking bench for the feedback selector
module fully_closed_loop_position_feedback_tb;
  typedef struct packed {
    logic [11:0] cfg;
    logic [19:0] cyc;
    logic [5:0]  exp;
  } fcl_row_s;

  logic        mclk     = 1'b0;
  logic        rst_n    = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [31:0] wdata    = 32'h0;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        cld_pin  = 1'b0;
  logic [7:0]  speed    = 8'h00;
  logic [31:0] gap      = 32'h00001000;
  logic [31:0] rdata;
  logic [31:0] motor_pos;
  logic [31:0] load_pos;
  logic [31:0] fb_pos;
  logic        fcl_run;
  logic [1:0]  method;
  logic        p_alm;
  logic        c_wrn;
  logic        e_alm;
  logic        irq;
  int          err_count    = 0;
  int          total_checks = 0;
  int          cyc_cnt      = 0;
  wire  [5:0]  obs = {method, fcl_run, e_alm, c_wrn, p_alm};

  // Rows: configuration, cycle in ns, then {method, run, enc, cycle, param}
  fcl_row_s rows [11] = '{
    '{12'h007, 20'hF4240, 6'h01},  // Three axes
    '{12'h025, 20'hF4240, 6'h01},  // Other operation mode
    '{12'h015, 20'hF4240, 6'h18},  // Positioning mode
    '{12'h005, 20'h1E847, 6'h1A},  // One axis, just under limit
    '{12'h005, 20'h1E848, 6'h18},  // One axis, at limit
    '{12'h006, 20'h3D08F, 6'h1A},  // Two axes, just under limit
    '{12'h006, 20'h3D090, 6'h18},  // Two axes, at limit
    '{12'h206, 20'hF4240, 6'h04},  // Two axes, A/B/Z load
    '{12'h046, 20'hF4240, 6'h04},  // Two axes, four-wire motor
    '{12'h205, 20'hF4240, 6'h18},  // One axis, A/B/Z load
    '{12'h003, 20'hF4240, 6'h00}   // Loop system off
  };

  // ==============================================================
  // Clock, design and partner
  always #20 mclk = ~mclk;

  fcl_top fcl_top_inst (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cld_pin(cld_pin), .motor_pos(motor_pos), .load_pos(load_pos), .fb_pos(fb_pos),
    .fcl_run(fcl_run), .method(method), .parameter_error_alarm(p_alm),
    .comm_cycle_setting_warning(c_wrn), .load_encoder_error_alarm(e_alm), .irq(irq)
  );

  fcl_enc_model fcl_enc_model_inst (
    .mclk(mclk), .rst_n(rst_n), .speed(speed), .gap(gap), .motor_pos(motor_pos), .load_pos(load_pos)
  );

  // ==============================================================
  // Bus tasks and closing
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // Alarms land one cycle after apply, method one more
  task automatic apply();
    wr_reg(fcl_pkg::A_CTRL, 32'h1);
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Guard against a hang; the run needs well under this
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      err_count++;
      end_of_test();
    end
  end

  // ==============================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK({irq, obs}, 7'h00)
    chk_rd(fcl_pkg::A_CYC, 32'h0000F424);
    chk_rd(fcl_pkg::A_FILT, 32'h00000064);
    chk_rd(fcl_pkg::A_STAT, 32'h0);
    chk_rd(fcl_pkg::A_MASK, 32'h0);
    chk_rd(8'h40, 32'h0);
    $display("test reset done");

    // Table of configurations, each cleared by write-one afterwards
    for (int i = 0; i < 11; i++) begin
      wr_reg(fcl_pkg::A_CFG, {20'h0, rows[i].cfg});
      wr_reg(fcl_pkg::A_CYC, {12'h0, rows[i].cyc});
      apply();
      `CHK(obs, rows[i].exp)
      wr_reg(fcl_pkg::A_STAT, 32'h7);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(obs[2:0], 3'h0)
    end
    $display("test table done");

    // Interrupt: raise, hold past a fix, mask, clear
    wr_reg(fcl_pkg::A_MASK, 32'h1);
    wr_reg(fcl_pkg::A_CFG, 32'h007);
    apply();
    wr_reg(fcl_pkg::A_CFG, 32'h005);
    repeat (2) @(posedge mclk);
    #1;
    `CHK({irq, p_alm}, 2'b11)
    wr_reg(fcl_pkg::A_MASK, 32'h0);
    #1;
    `CHK(irq, 1'b0)
    wr_reg(fcl_pkg::A_MASK, 32'h1);
    wr_reg(fcl_pkg::A_STAT, 32'h1);
    #1;
    `CHK({irq, p_alm}, 2'b00)
    $display("test interrupt done");

    // Filter at the top setting forces load feedback
    wr_reg(fcl_pkg::A_FILT, 32'h1194);
    apply();
    `CHK(method, 2'h2)
    `CHK(fb_pos, load_pos)
    // Blend drifts from motor towards load at standstill
    wr_reg(fcl_pkg::A_FILT, 32'h1193);
    apply();
    repeat (5000) @(posedge mclk);
    #1;
    `CHK(method, 2'h1)
    `CHK(($signed(fb_pos) > 0) && ($signed(fb_pos) <= 32'sh1000), 1'b1)
    $display("test filter done");

    // Switch select: semi until pin or command, motor tracked while turning
    wr_reg(fcl_pkg::A_CFG, 32'h00D);
    speed <= 8'h03;
    apply();
    `CHK(method, 2'h0)
    `CHK(fb_pos, motor_pos - 32'h3)
    cld_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    `CHK(method, 2'h1)
    cld_pin <= 1'b0;
    wr_reg(fcl_pkg::A_CTRL, 32'h2);
    repeat (8) @(posedge mclk);
    #1;
    `CHK(method, 2'h1)
    $display("test switch done");
    end_of_test();
  end
endmodule
